// ---- hdl/ecr_pkg.sv ----
// Package: constants and types for the error code reporter
package ecr_pkg;
    // Error numbers as two BCD digits (A-digit coded as hex A)
    localparam logic [7:0] ECR_ERR_NONE     = 8'h00;
    localparam logic [7:0] ECR_ERR_HV       = 8'h01;
    localparam logic [7:0] ECR_ERR_SYNTAX   = 8'h02;
    localparam logic [7:0] ECR_ERR_OVF      = 8'h03;
    localparam logic [7:0] ECR_ERR_KEY      = 8'h04;
    localparam logic [7:0] ECR_ERR_FILTER   = 8'h05;
    localparam logic [7:0] ECR_ERR_ZERO     = 8'h06;
    localparam logic [7:0] ECR_ERR_CMDBUF   = 8'h07;
    localparam logic [7:0] ECR_ERR_XREF_OV  = 8'h08;
    localparam logic [7:0] ECR_ERR_XREF_UR  = 8'h09;
    localparam logic [7:0] ECR_ERR_OVRNG    = 8'h10;
    localparam logic [7:0] ECR_ERR_FAST     = 8'h12;
    localparam logic [7:0] ECR_ERR_ROM      = 8'h14;
    localparam logic [7:0] ECR_ERR_RAM      = 8'h15;
    localparam logic [7:0] ECR_ERR_LINE     = 8'h16;
    localparam logic [7:0] ECR_ERR_NOCOMM   = 8'h17;
    localparam logic [7:0] ECR_ERR_RESYNC   = 8'h24;
    localparam logic [7:0] ECR_ERR_ECHO_TO  = 8'h30;
    localparam logic [3:0] ECR_UART_HI      = 4'h3;
    localparam logic [7:0] ECR_ERR_ISO_INT  = 8'hA1;
    localparam logic [7:0] ECR_ERR_ISO_UART = 8'hA5;
    localparam logic [7:0] ECR_ERR_ISO_CMD  = 8'hA7;

    // Four-letter name tags shown after the number
    typedef enum logic [3:0] {
        ECR_TAG_BLANK  = 4'h0,
        ECR_TAG_HV     = 4'h1,
        ECR_TAG_NUMERIC_OVERFLOW_TAG   = 4'h2,
        ECR_TAG_TEMP   = 4'h3,
        ECR_TAG_KEY    = 4'h4,
        ECR_TAG_FILT   = 4'h5,
        ECR_TAG_ZERO   = 4'h6,
        ECR_TAG_BUS    = 4'h7,
        ECR_TAG_XREF   = 4'h8,
        ECR_TAG_HHHH   = 4'h9,
        ECR_TAG_FAST   = 4'hA,
        ECR_TAG_MEM    = 4'hB,
        ECR_TAG_LINE   = 4'hC,
        ECR_TAG_HWFLT  = 4'hD,
        ECR_TAG_UART   = 4'hE,
        ECR_TAG_ISO    = 4'hF
    } ecr_tag_t;

    // Voltage thresholds in millivolts, and width in bits of the voltage inputs
    localparam int ECR_HV_LIMIT_MV   = 16500;
    localparam int ECR_XREF_MIN_MV   = 500;
    localparam int ECR_FLASH_DC_MV   = 42400;
    localparam int ECR_FLASH_AC_MV   = 30000;
    localparam int ECR_VOLT_W        = 18;

    localparam int ECR_CMD_BUF_BYTES = 64;
    localparam int ECR_CONV_ITER_MAX = 10;

    // Timing
    localparam int ECR_CLK_HZ        = 25000000;
    localparam int ECR_FLASH_MS      = 500;
    localparam int ECR_FLASH_CYC     = ECR_CLK_HZ / 1000 * ECR_FLASH_MS;
    localparam int ECR_ECHO_TO_US    = 1000;
    localparam int ECR_ECHO_TO_CYC   = ECR_CLK_HZ / 1000000 * ECR_ECHO_TO_US;
endpackage : ecr_pkg

// ---- hdl/ecr_reporter.sv ----
// Error code reporter: fault detection, display code and status buffer
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// RULE1: fault shows two-digit number plus four-letter name
// RULE2: number stored in status buffer, read by query
// RULE3: ohms with over 16.5 V raises 01
// RULE4: bad remote characters raise 02, no display
// RULE5: math register overflow raises 03 overflow name
// RULE6: temperature conversion range/converge fault raises 03
// RULE7: invalid keyboard sequence raises 04
// RULE8: async rate with non-5ms filter raises 05
// RULE9: zero program with AC functions raises 06
// RULE10: 64-byte command buffer overflow raises 07
// RULE11: external reference over 16.5 V raises 08
// RULE12: reference difference under 0.5 V raises 09
// RULE13: overrange raises 10 showing H string
// RULE14: reading rate too fast raises 12
// RULE15: program checksum 14, working memory 15
// RULE16: unknown mains frequency raises 16
// RULE17: missing echo within timeout raises 30
// RULE18: serial faults give 3x, x=parity+overrun+framing
// RULE19: no converter communication raises 17
// RULE20: resync failure in external sync raises 24
// RULE21: converter reports A1, A5, A7
// RULE22: math in use flashes H each second; code flashes only with input over 42.4 V dc/30 V ac or overrange
// RULE23: newest error overwrites stored number
module ecr_reporter #(
    parameter int ECHO_TO_CYC = ecr_pkg::ECR_ECHO_TO_CYC,   // Echo timeout in cycles
    parameter int FLASH_CYC   = ecr_pkg::ECR_FLASH_CYC,     // Half period of H flash
    parameter int BUF_BYTES   = ecr_pkg::ECR_CMD_BUF_BYTES  // Command buffer depth
) (
    input  wire logic                           core_clk,         // Clock
    input  wire logic                           rst,              // Sync reset, high
    // Measurement state
    input  wire logic                           ohms_active,      // Ohms requested or active
    input  wire logic [ecr_pkg::ECR_VOLT_W-1:0] input_mv,         // Input magnitude, mV
    input  wire logic                           ac_volts_function,   // AC volts selected
    input  wire logic                           ac_plus_dc_function, // AC+DC selected
    input  wire logic                           overrange,        // Analog overrange
    // Math
    input  wire logic                           math_in_use,      // Math program in use
    input  wire logic                           math_overflow,    // Math register out of range
    input  wire logic                           zero_offset_program, // Zero program requested
    input  wire logic                           external_ratio_program, // Ratio program in use
    input  wire logic [ecr_pkg::ECR_VOLT_W-1:0] xref_hi_mv,       // Ext ref hi magnitude, mV
    input  wire logic [ecr_pkg::ECR_VOLT_W-1:0] xref_lo_mv,       // Ext ref lo magnitude, mV
    input  wire logic [ecr_pkg::ECR_VOLT_W-1:0] xref_diff_mv,     // Hi-lo diff magnitude, mV
    input  wire logic                           temp_conv_range,  // Conversion input out of range
    input  wire logic                           temp_conv_step,   // One conversion iteration done
    input  wire logic                           temp_conv_done,   // Conversion converged
    input  wire logic                           temp_conv_start,  // Conversion begins
    // Front panel and rate
    input  wire logic                           key_invalid,      // Invalid key sequence
    input  wire logic                           async_rate,       // Asynchronous rate active
    input  wire logic                           filter_req,       // Filter selection pulse
    input  wire logic                           filter_is_5ms,    // Requested filter is 5 ms
    input  wire logic                           rate_too_fast,    // Rate too fast for setup
    // Remote bus
    input  wire logic                           cmd_char_valid,   // Command char arrives
    input  wire logic                           cmd_char_bad,     // Char is invalid
    input  wire logic                           cmd_char_take,    // Parser consumes a char
    input  wire logic                           status_query_command, // Status query pulse
    // Self test
    input  wire logic                           rom_fail,         // Checksum test failed
    input  wire logic                           ram_fail,         // Memory test failed
    input  wire logic                           line_unknown,     // Mains frequency unknown
    // Converter link
    input  wire logic                           echo_expect,      // Echo awaited from converter
    input  wire logic                           echo_seen,        // Echo arrived
    input  wire logic                           link_dead,        // No communication at all
    input  wire logic                           resync_fail,      // Resync failed
    input  wire logic                           ext_sync_mode,    // Ext trigger with sync rate
    input  wire logic                           rx_parity,        // Local parity error
    input  wire logic                           rx_overrun,       // Local overrun error
    input  wire logic                           rx_framing,       // Local framing error
    input  wire logic                           iso_undef_int,    // Converter undefined interrupt
    input  wire logic                           iso_serial_err,   // Converter serial fault
    input  wire logic                           iso_bad_cmd,      // Converter illegal command
    // Outputs
    output var  logic                           err_show,         // Error message on display
    output var  logic [7:0]                     err_code,         // Displayed error number
    output var  ecr_pkg::ecr_tag_t              err_tag,          // Displayed name tag
    output var  logic [7:0]                     status_err,       // Status buffer number
    output var  logic                           status_valid,     // Query answer strobe
    output var  logic [7:0]                     status_data,      // Query answer number
    output var  logic                           flash_h,          // H flash on display
    output logic                                cmd_buf_full      // Command buffer full
);
    import ecr_pkg::*;

    initial begin
        if (ECHO_TO_CYC < 1 || FLASH_CYC < 1 || BUF_BYTES < 2) begin
            $error("ecr_reporter: bad parameter");
        end
    end

    localparam int CW = $clog2(BUF_BYTES + 1);
    localparam int EW = $clog2(ECHO_TO_CYC + 1);
    localparam int FW = $clog2(FLASH_CYC + 1);
    localparam logic [ECR_VOLT_W-1:0] HV_LIM = ECR_VOLT_W'(ECR_HV_LIMIT_MV);
    localparam logic [ECR_VOLT_W-1:0] XR_MIN = ECR_VOLT_W'(ECR_XREF_MIN_MV);
    localparam logic [ECR_VOLT_W-1:0] FL_DC  = ECR_VOLT_W'(ECR_FLASH_DC_MV);
    localparam logic [ECR_VOLT_W-1:0] FL_AC  = ECR_VOLT_W'(ECR_FLASH_AC_MV);

    // ------------------------------------------------------------
    // Command buffer fill and timers
    // ------------------------------------------------------------
    logic [CW-1:0] fill_q;
    logic          cmd_ovf;
    logic [EW-1:0] echo_cnt_q;
    logic          echo_to;
    logic [3:0]    iter_q;
    logic          conv_fail;
    logic [FW-1:0] flash_cnt_q;

    // Full is combinational so a char in the same cycle sees it
    assign cmd_buf_full = (fill_q == CW'(BUF_BYTES));
    assign cmd_ovf      = cmd_char_valid && cmd_buf_full && !cmd_char_take; // RULE10

    always_ff @(posedge core_clk) begin
        if (rst) begin
            fill_q <= '0;
        end else if (cmd_char_valid && !cmd_char_take && !cmd_buf_full) begin
            fill_q <= fill_q + CW'(1);
        end else if (!cmd_char_valid && cmd_char_take && fill_q != '0) begin
            fill_q <= fill_q - CW'(1);
        end
    end

    // Count waits for echo; one overflow event per wait
    assign echo_to = echo_expect && !echo_seen && (echo_cnt_q == EW'(ECHO_TO_CYC - 1)); // RULE17
    always_ff @(posedge core_clk) begin
        if (rst || !echo_expect || echo_seen) begin
            echo_cnt_q <= '0;
        end else if (echo_cnt_q != EW'(ECHO_TO_CYC)) begin
            echo_cnt_q <= echo_cnt_q + EW'(1);
        end
    end

    // Non-convergence after the iteration limit
    assign conv_fail = temp_conv_step && !temp_conv_done
                       && (iter_q == 4'(ECR_CONV_ITER_MAX - 1)); // RULE6
    always_ff @(posedge core_clk) begin
        if (rst || temp_conv_start || temp_conv_done) begin
            iter_q <= '0;
        end else if (temp_conv_step && iter_q != 4'(ECR_CONV_ITER_MAX)) begin
            iter_q <= iter_q + 4'h1;
        end
    end

    // ------------------------------------------------------------
    // Fault priority and code selection
    // ------------------------------------------------------------
    logic       hit;
    logic [7:0] code_d;
    ecr_tag_t   tag_d;
    logic       show_d;
    logic [2:0] fop;

    assign fop = {rx_framing, rx_overrun, rx_parity}; // RULE18

    // Hardware faults first: they make later readings meaningless
    always_comb begin
        hit    = 1'b1;
        show_d = 1'b1;
        code_d = ECR_ERR_NONE;
        tag_d  = ECR_TAG_BLANK;
        if (rom_fail) begin
            code_d = ECR_ERR_ROM;
            tag_d = ECR_TAG_MEM; // RULE15
        end else if (ram_fail) begin
            code_d = ECR_ERR_RAM;
            tag_d = ECR_TAG_MEM; // RULE15
        end else if (line_unknown) begin
            code_d = ECR_ERR_LINE;
            tag_d = ECR_TAG_LINE; // RULE16
        end else if (link_dead) begin
            code_d = ECR_ERR_NOCOMM;
            tag_d = ECR_TAG_HWFLT; // RULE19
        end else if (resync_fail && ext_sync_mode) begin
            code_d = ECR_ERR_RESYNC;
            tag_d = ECR_TAG_HWFLT; // RULE20
        end else if (fop != 3'b000) begin
            code_d = {ECR_UART_HI, 1'b0, fop};
            tag_d = ECR_TAG_UART; // RULE18
        end else if (echo_to) begin
            code_d = ECR_ERR_ECHO_TO;
            tag_d = ECR_TAG_UART; // RULE17
        end else if (iso_undef_int) begin
            code_d = ECR_ERR_ISO_INT;
            tag_d = ECR_TAG_ISO; // RULE21
        end else if (iso_serial_err) begin
            code_d = ECR_ERR_ISO_UART;
            tag_d = ECR_TAG_ISO; // RULE21
        end else if (iso_bad_cmd) begin
            code_d = ECR_ERR_ISO_CMD;
            tag_d = ECR_TAG_ISO; // RULE21
        end else if (ohms_active && input_mv > HV_LIM) begin
            code_d = ECR_ERR_HV;
            tag_d = ECR_TAG_HV; // RULE3
        end else if (external_ratio_program && (xref_hi_mv > HV_LIM || xref_lo_mv > HV_LIM)) begin
            code_d = ECR_ERR_XREF_OV;
            tag_d = ECR_TAG_XREF; // RULE11
        end else if (external_ratio_program && xref_diff_mv < XR_MIN) begin
            code_d = ECR_ERR_XREF_UR;
            tag_d = ECR_TAG_XREF; // RULE12
        end else if (overrange) begin
            code_d = ECR_ERR_OVRNG;
            tag_d = ECR_TAG_HHHH; // RULE13
        end else if (math_overflow) begin
            code_d = ECR_ERR_OVF;
            tag_d = ECR_TAG_NUMERIC_OVERFLOW_TAG; // RULE5
        end else if (temp_conv_range || conv_fail) begin
            code_d = ECR_ERR_OVF;
            tag_d = ECR_TAG_TEMP; // RULE6
        end else if (zero_offset_program && (ac_volts_function || ac_plus_dc_function)) begin
            code_d = ECR_ERR_ZERO;
            tag_d = ECR_TAG_ZERO; // RULE9
        end else if (async_rate && filter_req && !filter_is_5ms) begin
            code_d = ECR_ERR_FILTER;
            tag_d = ECR_TAG_FILT; // RULE8
        end else if (rate_too_fast) begin
            code_d = ECR_ERR_FAST;
            tag_d = ECR_TAG_FAST; // RULE14
        end else if (key_invalid) begin
            code_d = ECR_ERR_KEY;
            tag_d = ECR_TAG_KEY; // RULE7
        end else if (cmd_ovf) begin
            code_d = ECR_ERR_CMDBUF;
            tag_d = ECR_TAG_BUS; // RULE10
        end else if (cmd_char_valid && cmd_char_bad) begin
            code_d = ECR_ERR_SYNTAX; // RULE4
            show_d = 1'b0;
        end else begin
            hit    = 1'b0;
            show_d = 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Display and status buffer
    // ------------------------------------------------------------
    // Display holds the latest shown fault until reset
    always_ff @(posedge core_clk) begin
        if (rst) begin
            err_show <= 1'b0;
            err_code <= ECR_ERR_NONE;
            err_tag  <= ECR_TAG_BLANK;
        end else if (hit && show_d) begin
            err_show <= 1'b1; // RULE1
            err_code <= code_d;
            err_tag  <= tag_d;
        end
    end

    // Error 02 lands here although the display ignores it
    always_ff @(posedge core_clk) begin
        if (rst) begin
            status_err <= ECR_ERR_NONE;
        end else if (hit) begin
            status_err <= code_d; // RULE2 RULE23
        end
    end

    // Answer reflects the buffer before any same-cycle update
    always_ff @(posedge core_clk) begin
        if (rst) begin
            status_valid <= 1'b0;
            status_data  <= ECR_ERR_NONE;
        end else begin
            status_valid <= status_query_command; // RULE2
            if (status_query_command) begin
                status_data <= status_err;
            end
        end
    end

    // ------------------------------------------------------------
    // H flash while math in use and input over 42.4 V dc/30 V ac or overrange
    // ------------------------------------------------------------
    logic flash_cond;
    assign flash_cond = math_in_use && (overrange
                        || (!ac_volts_function && !ac_plus_dc_function && input_mv > FL_DC)
                        || ((ac_volts_function || ac_plus_dc_function) && input_mv > FL_AC));

    // Restart on every drop so each episode begins dark
    always_ff @(posedge core_clk) begin
        if (rst || !flash_cond) begin
            flash_cnt_q <= '0;
            flash_h     <= 1'b0;
        end else if (flash_cnt_q == FW'(FLASH_CYC - 1)) begin
            flash_cnt_q <= '0;
            flash_h     <= !flash_h; // RULE22
        end else begin
            flash_cnt_q <= flash_cnt_q + FW'(1);
        end
    end
endmodule : ecr_reporter

`default_nettype wire

// ---- tb/ecr_reporter_asserts.sv ----
// Checker of the error reporter port behaviour
`timescale 1ns/1ps
`default_nettype none
module ecr_reporter_asserts
    import ecr_pkg::*;
(
    input wire logic       core_clk, rst, rom_fail, ram_fail, line_unknown, link_dead,
    input wire logic       resync_fail, rx_parity, rx_overrun, rx_framing, math_in_use,
    input wire logic       status_query_command, status_valid, err_show, flash_h,
    input wire logic [7:0] status_data, status_err, err_code,
    input wire ecr_tag_t   err_tag
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);
    wire hi3 = rom_fail | ram_fail | line_unknown;
    wire rxe = rx_parity | rx_overrun | rx_framing;

    chk_rom_code: assert property (rom_fail |=>
        err_code == 8'h14 && err_tag == ECR_TAG_MEM) else $error("rom fault not shown");
    chk_ram_code: assert property (ram_fail && !rom_fail |=> status_err == 8'h15)
        else $error("ram fault not stored");
    chk_line_code: assert property (line_unknown && !rom_fail && !ram_fail |=>
        err_code == 8'h16) else $error("line fault not shown");
    chk_link_dead: assert property (link_dead && !hi3 |=> err_tag == ECR_TAG_HWFLT)
        else $error("dead link not shown");
    chk_uart_sum: assert property (rxe && !hi3 && !link_dead && !resync_fail |=>
        err_code == {5'h06, $past(rx_framing), $past(rx_overrun), $past(rx_parity)})
        else $error("serial fault sum wrong");
    chk_query_data: assert property (status_query_command |=>
        status_valid && status_data == $past(status_err)) else $error("query answer wrong");
    chk_query_idle: assert property (!status_query_command |=> !status_valid)
        else $error("answer without query");
    chk_flash_off: assert property (!math_in_use |=> !flash_h)
        else $error("flash without math");
    chk_show_store: assert property ($rose(err_show) |-> err_code == status_err)
        else $error("shown and stored differ");

    cov_rom: cover property (rom_fail ##1 err_show);
    cov_query: cover property (status_query_command ##1 status_valid);
    cov_flash: cover property ($rose(flash_h));
endmodule : ecr_reporter_asserts
bind ecr_reporter ecr_reporter_asserts u_chk (.*);
`default_nettype wire

// ---- tb/ecr_remote_model.sv ----
// Remote bus controller model issuing status queries
`timescale 1ns/1ps
`default_nettype none
module ecr_remote_model (
    input  wire logic       core_clk,             // Clock
    input  wire logic       rst,                  // Reset
    input  wire logic       ask,                  // Start one query
    input  wire logic [3:0] gap,                  // Idle cycles before the query
    input  wire logic       status_valid,         // Answer strobe
    input  wire logic [7:0] status_data,          // Answer number
    output var  logic       status_query_command, // Query pulse
    output var  logic       got,                  // Answer taken
    output var  logic [7:0] reply                 // Number taken
);
    logic [4:0] cnt_q;
    always_ff @(posedge core_clk) begin
        if (rst) begin
            cnt_q <= 5'h00;
            status_query_command <= 1'b0;
        end else begin
            status_query_command <= (cnt_q == 5'h01);
            if (ask) cnt_q <= {1'b0, gap} + 5'h01;
            else if (cnt_q != 5'h00) cnt_q <= cnt_q - 5'h01;
        end
    end
    // Data is only valid on the strobe edge, so take it there
    always_ff @(posedge core_clk) begin
        got <= !rst && status_valid;
        if (status_valid) reply <= status_data;
    end
endmodule : ecr_remote_model
`default_nettype wire

// ---- tb/tb_ecr_reporter.sv ----
// Testbench of the error code reporter
`timescale 1ns/1ps
`default_nettype none
module tb_ecr_reporter;
    import ecr_pkg::*;
    logic core_clk, rst = 1'b1, ask = 0, got, status_query_command;
    logic [3:0] gap = 0;
    logic [7:0] reply, err_code, status_err, status_data;
    logic ohms_active = 0, ac_volts_function = 0, ac_plus_dc_function = 0, overrange = 0;
    logic math_in_use = 0, math_overflow = 0, zero_offset_program = 0;
    logic external_ratio_program = 0, temp_conv_range = 0, temp_conv_step = 0;
    logic temp_conv_done = 0, temp_conv_start = 0, key_invalid = 0, async_rate = 0;
    logic filter_req = 0, filter_is_5ms = 0, rate_too_fast = 0, cmd_char_valid = 0;
    logic cmd_char_bad = 0, cmd_char_take = 0, rom_fail = 0, ram_fail = 0, line_unknown = 0;
    logic echo_expect = 0, echo_seen = 0, link_dead = 0, resync_fail = 0, ext_sync_mode = 0;
    logic rx_parity = 0, rx_overrun = 0, rx_framing = 0, iso_undef_int = 0;
    logic iso_serial_err = 0, iso_bad_cmd = 0;
    logic [17:0] input_mv = 0, xref_hi_mv = 0, xref_lo_mv = 0, xref_diff_mv = 18'h001F4;
    logic err_show, status_valid, flash_h, cmd_buf_full;
    ecr_tag_t err_tag;
    int err_total = 0, n_checks = 0;
    logic [7:0] exp_c [19] = '{8'h14, 8'h15, 8'h16, 8'h17, 8'h24, 8'hA1, 8'hA5, 8'hA7,
        8'h01, 8'h08, 8'h09, 8'h10, 8'h03, 8'h06, 8'h05, 8'h12, 8'h04, 8'h03, 8'h08};
    ecr_tag_t exp_t [19] = '{ECR_TAG_MEM, ECR_TAG_MEM, ECR_TAG_LINE, ECR_TAG_HWFLT,
        ECR_TAG_HWFLT, ECR_TAG_ISO, ECR_TAG_ISO, ECR_TAG_ISO, ECR_TAG_HV, ECR_TAG_XREF,
        ECR_TAG_XREF, ECR_TAG_HHHH, ECR_TAG_NUMERIC_OVERFLOW_TAG, ECR_TAG_ZERO, ECR_TAG_FILT,
        ECR_TAG_FAST, ECR_TAG_KEY, ECR_TAG_TEMP, ECR_TAG_XREF};

    ecr_reporter #(.ECHO_TO_CYC(8), .FLASH_CYC(4), .BUF_BYTES(64)) dut (.*);
    ecr_remote_model u_remote (.*);

    initial begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end

    task automatic tick(int n);
        repeat (n) @(posedge core_clk);
    endtask : tick

    task automatic cmp8(logic [7:0] act, logic [7:0] exp, string m);
        n_checks++;
        if (act !== exp) begin
            err_total++;
            $display("unexpected at %0t: %s", $time, m);
        end
    endtask : cmp8

    task automatic disp(logic [7:0] c, ecr_tag_t t);
        cmp8(err_code, c, "error number");
        cmp8({4'h0, err_tag}, {4'h0, t}, "name tag");
        cmp8(status_err, c, "stored number");
        cmp8({7'h00, err_show}, 8'h01, "message shown");
    endtask : disp

    task automatic setf(int i, logic v);
        case (i)
            0: rom_fail <= v;
            1: ram_fail <= v;
            2: line_unknown <= v;
            3: link_dead <= v;
            4: {resync_fail, ext_sync_mode} <= {v, v};
            5: iso_undef_int <= v;
            6: iso_serial_err <= v;
            7: iso_bad_cmd <= v;
            8: {ohms_active, input_mv} <= {v, v ? 18'h04075 : 18'h00000};
            9: {external_ratio_program, xref_hi_mv} <= {v, v ? 18'h04075 : 18'h00000};
            10: {external_ratio_program, xref_diff_mv} <= {v, v ? 18'h001F3 : 18'h001F4};
            11: overrange <= v;
            12: math_overflow <= v;
            13: {zero_offset_program, ac_plus_dc_function} <= {v, v};
            14: {async_rate, filter_req} <= {v, v};
            15: rate_too_fast <= v;
            16: key_invalid <= v;
            17: temp_conv_range <= v;
            default: {external_ratio_program, xref_lo_mv} <= {v, v ? 18'h04075 : 18'h00000};
        endcase
    endtask : setf

    task automatic s_table(int lo, int hi);
        for (int i = lo; i < hi; i++) begin
            tick(1);
            setf(i, 1'b1);
            tick(1);
            setf(i, 1'b0);
            #1 disp(exp_c[i], exp_t[i]);
        end
    endtask : s_table

    task automatic quiet(logic v);
        {async_rate, filter_req, filter_is_5ms, resync_fail, zero_offset_program} <= {5{v}};
        {ohms_active, external_ratio_program} <= {v, v};
        {input_mv, xref_hi_mv, xref_lo_mv} <= {3{v ? 18'h04074 : 18'h00000}};
    endtask : quiet

    task automatic s_quiet();
        tick(1);
        quiet(1'b1);
        tick(1);
        quiet(1'b0);
        #1 cmp8(status_err, 8'h37, "fault at threshold");
    endtask : s_quiet

    task automatic s_uart();
        for (int x = 1; x < 8; x++) begin
            tick(1);
            {rx_framing, rx_overrun, rx_parity} <= 3'(x);
            tick(1);
            {rx_framing, rx_overrun, rx_parity} <= 3'h0;
            #1 disp({5'h06, 3'(x)}, ECR_TAG_UART);
        end
    endtask : s_uart

    task automatic s_echo();
        tick(1);
        echo_expect <= 1'b1;
        repeat (4) begin
            tick(4);
            echo_seen <= 1'b1;
            tick(1);
            echo_seen <= 1'b0;
        end
        #1 cmp8(err_code, 8'h37, "early echo timeout");
        tick(10);
        echo_expect <= 1'b0;
        #1 disp(8'h30, ECR_TAG_UART);
    endtask : s_echo

    task automatic s_temp();
        tick(1);
        temp_conv_start <= 1'b1;
        tick(1);
        temp_conv_start <= 1'b0;
        for (int s = 0; s < 19; s++) begin
            temp_conv_step <= (s != 9);
            temp_conv_done <= (s == 9);
            tick(1);
        end
        {temp_conv_step, temp_conv_done} <= 2'h0;
        #1 cmp8(err_code, 8'h30, "early conversion fault");
        tick(1);
        temp_conv_step <= 1'b1;
        tick(1);
        temp_conv_step <= 1'b0;
        #1 disp(8'h03, ECR_TAG_TEMP);
    endtask : s_temp

    task automatic s_cmdbuf();
        tick(1);
        cmd_char_valid <= 1'b1;
        tick(64);
        #1 cmp8({7'h00, cmd_buf_full}, 8'h01, "buffer not full");
        cmp8(err_code, 8'h03, "overflow too soon");
        tick(1);
        cmd_char_valid <= 1'b0;
        #1 disp(8'h07, ECR_TAG_BUS);
        tick(1);
        cmd_char_take <= 1'b1;
        tick(64);
        {cmd_char_valid, cmd_char_bad} <= 2'h3;
        tick(1);
        {cmd_char_valid, cmd_char_bad, cmd_char_take} <= 3'h0;
        #1 cmp8({7'h00, cmd_buf_full}, 8'h00, "buffer not drained");
        cmp8(err_code, 8'h07, "syntax error shown");
        cmp8(status_err, 8'h02, "syntax error not stored");
    endtask : s_cmdbuf

    task automatic s_query(logic [3:0] g);
        int k = 0;
        tick(1);
        gap <= g;
        ask <= 1'b1;
        tick(1);
        ask <= 1'b0;
        do begin
            tick(1);
            #1 k++;
        end while (got !== 1'b1 && k < 30);
        cmp8(reply, 8'h02, "query answer");
    endtask : s_query

    task automatic s_flash();
        for (int c = 0; c < 3; c++) begin
            int t = 0;
            logic last;
            tick(1);
            math_in_use <= 1'b1;
            input_mv <= (c == 0) ? 18'h0A5A1 : 18'h07531;
            ac_volts_function <= (c == 1);
            overrange <= (c == 2);
            tick(3);
            #1 last = flash_h;
            repeat (16) begin
                tick(1);
                #1 t += (flash_h !== last);
                last = flash_h;
            end
            cmp8(8'(t), 8'h04, "flash toggles");
            tick(1);
            {math_in_use, ac_volts_function, overrange} <= 3'h0;
            tick(2);
            #1 cmp8({7'h00, flash_h}, 8'h00, "flash after math off");
        end
    endtask : s_flash

    task automatic complete_run();
        if (err_total == 0 && n_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : complete_run

    initial begin
        tick(5000);
        err_total++;
        complete_run();
    end

    initial begin
        tick(2);
        rst <= 1'b0;
        s_table(0, 5);
        s_table(5, 8);
        s_table(8, 13);
        s_table(13, 19);
        s_uart();
        s_quiet();
        s_echo();
        s_temp();
        s_cmdbuf();
        s_query(4'h0);
        s_query(4'h5);
        s_flash();
        complete_run();
    end
endmodule : tb_ecr_reporter
`default_nettype wire
